// ---- pkg/pio_pkg.sv ----
// Purpose: Shared constants and types for the port I/O and counter control block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: A register's byte address is its index times four.
package pio_pkg;
    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_PORT_OUT = 6'h00;
    localparam logic [IDX_W-1:0] IDX_PORT_DIR = 6'h01;
    localparam logic [IDX_W-1:0] IDX_PORT_PIN = 6'h02;
    localparam logic [IDX_W-1:0] IDX_CNT_CTRL = 6'h03;
    localparam logic [IDX_W-1:0] IDX_PORT_CFG = 6'h04;
    localparam logic [IDX_W-1:0] IDX_TMR_ROUTE = 6'h05;
    localparam logic [IDX_W-1:0] IDX_NARROW_OUT = 6'h06;
    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int CNT_TIMER_16BIT_EN_BIT = 7;
    localparam int CNT_TIMER_8BIT_EN_BIT = 6;
    localparam int CNT_SYNC_BIT = 5;
    localparam logic [7:0] CNT_RSVD_ONES = 8'h1f;
    localparam int CFG_PUSH_PULL_BIT = 0;
    localparam int CFG_PIN5_SEL_BIT = 1;
    localparam int CFG_DIGITAL_BIT = 2;
    localparam int CFG_COMP_EN_BIT = 3;
    localparam int CFG_EDGE_SRC_BIT = 4;
    localparam int ROUTE_TIMER_8BIT_BIT = 0;
    localparam int ROUTE_TIMER_16BIT_BIT = 1;
    localparam int ROUTE_COMMON_LO = 4;
    localparam int ROUTE_COMMON_HI = 5;
    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [7:0] PORT_OUT_RESET = 8'h00;
    localparam logic [7:0] PORT_DIR_RESET = 8'h00;
    localparam logic [7:0] PORT_CFG_RESET = 8'h00;
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    localparam logic [3:0] NARROW_OUT_RESET = 4'h0;
    // ----------------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic timer8bit;
        logic timer16bit;
        logic combo;
    } pio_timer_out_t;
    typedef struct packed {
        logic timer16bitEn;
        logic timer8bitEn;
        logic sync;
    } pio_cnt_ctrl_t;
endpackage

// ---- design/pio_sync2.sv ----
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Inputs are levels from outside the clock domain.
// Notes: Only the second stage may be read by logic.
`timescale 1ns/1ps
`default_nettype none
module pio_sync2 #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            dout <= '0;
        end else begin
            stage1_reg <= din;
            dout <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

// ---- design/pio_pin_drive.sv ----
// Purpose: Output driver of one wide-port line.
// Assumes: Direction, drive style and data come from registers on clk_sys.
// Notes: Open-drain lines drive only a low; a high is released to the pull-up.
`timescale 1ns/1ps
`default_nettype none
module pio_pin_drive (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic dirOut,
    input wire logic pushPull,
    input wire logic dataOut,
    input wire logic pullOpt,
    output logic padOut,
    output logic padOe,
    output logic padPullEn
);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            padOut <= 1'b0;
            padOe <= 1'b0;
            padPullEn <= 1'b0;
        end else begin
            padOut <= pushPull & dataOut;
            padOe <= dirOut & (pushPull | ~dataOut);
            padPullEn <= pullOpt;
        end
    end
endmodule
`default_nettype wire

// ---- design/pio_top.sv ----
// Purpose: Wide-port I/O, narrow-port routing and counter enable control.
// Assumes: APB slave on clk_sys; pins are synchronised before use.
// Notes: Counter and comparator internals live outside this block.
//
// Contract
// - Each wide-port line is independently an input or output under software.
// - One global setting makes all wide-port outputs push-pull or open-drain.
// - After power-on reset all wide-port lines are inputs.
// - A nonvolatile option connects pull-ups on all eight wide-port lines.
// - Wide-port inputs are combined in an AND and an OR wake-up gate.
// - Wide-port bit 0 may feed the edge detector in edge capture mode.
// - Entering stop mode powers down the narrow-port comparators.
// - Narrow pins 4, 5, 6 show 8-bit, 16-bit and combined timer outputs.
// - Common control bits 5:4 and timer control bits 1:0 route narrow outputs.
// - A dedicated select bit picks normal output or timer output on pin 5.
// - Counter control bits 7 and 6 enable, stop and report both counters.
// - Power-on reset clears both enables and the sync bit.
// - Sync bit is read/write and survives stop-mode recovery.
// - Counter control low five bits read as ones; writes ignored.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pio_top #(
    parameter int PORT_W = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [pio_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PORT_W-1:0] widePortIn,
    output logic [PORT_W-1:0] widePortOut,
    output logic [PORT_W-1:0] widePortOe,
    output logic [PORT_W-1:0] widePortPullEn,
    input wire logic pullupOption,
    input wire logic [2:0] narrowPortIn,
    output logic [3:0] narrowPortOut,
    input wire pio_pkg::pio_timer_out_t timerOut,
    input wire logic edgeCaptureMode,
    input wire logic stopMode,
    input wire logic stopRecover,
    output logic edgeCaptureIn,
    output logic wakeAnd,
    output logic wakeOr,
    output logic compPowerEn,
    output logic [2:0] recoverySrc,
    output pio_pkg::pio_cnt_ctrl_t cntCtrl,
    output logic timer8bitStart,
    output logic timer16bitStart
);
    // ----------------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------------
    logic [PORT_W-1:0] wideSync;
    logic [2:0] narrowSync;
    logic pullSync;

    pio_sync2 #(.W(PORT_W + 4)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .din({pullupOption, narrowPortIn, widePortIn}),
        .dout({pullSync, narrowSync, wideSync})
    );

    // ----------------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------------
    logic [pio_pkg::IDX_W-1:0] regIdx;
    logic setupPhase;
    logic wrEn;
    logic mapped;
    logic [7:0] rdByte;

    logic [PORT_W-1:0] portOut_reg;
    logic [PORT_W-1:0] portDir_reg;
    logic [7:0] portCfg_reg;
    logic [7:0] route_reg;
    logic [3:0] narrowOut_reg;

    assign regIdx = paddr[pio_pkg::ADDR_W-1:2];
    assign setupPhase = psel & ~penable;
    assign wrEn = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        mapped = (paddr[1:0] == 2'h0);
        rdByte = 8'h00;
        case (regIdx)
            pio_pkg::IDX_PORT_OUT: rdByte = portOut_reg;
            pio_pkg::IDX_PORT_DIR: rdByte = portDir_reg;
            pio_pkg::IDX_PORT_PIN: rdByte = wideSync;
            pio_pkg::IDX_CNT_CTRL: rdByte = {cntCtrl, pio_pkg::CNT_RSVD_ONES[4:0]};
            pio_pkg::IDX_PORT_CFG: rdByte = portCfg_reg;
            pio_pkg::IDX_TMR_ROUTE: rdByte = route_reg;
            pio_pkg::IDX_NARROW_OUT: rdByte = {4'h0, narrowOut_reg};
            default: mapped = 1'b0;
        endcase
    end

    // The answer is prepared in the setup cycle so every bus output is a flop.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~mapped;
            if (setupPhase) begin
                prdata <= (mapped && !pwrite) ? {24'h000000, rdByte} : 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            portDir_reg <= pio_pkg::PORT_DIR_RESET;
        end else if (wrEn && regIdx == pio_pkg::IDX_PORT_DIR) begin
            portDir_reg <= pwdata[PORT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            portOut_reg <= pio_pkg::PORT_OUT_RESET;
        end else if (wrEn && regIdx == pio_pkg::IDX_PORT_OUT) begin
            portOut_reg <= pwdata[PORT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            portCfg_reg <= pio_pkg::PORT_CFG_RESET;
            route_reg <= pio_pkg::ROUTE_RESET;
            narrowOut_reg <= pio_pkg::NARROW_OUT_RESET;
        end else if (wrEn) begin
            if (regIdx == pio_pkg::IDX_PORT_CFG) begin
                portCfg_reg <= pwdata[7:0];
            end
            if (regIdx == pio_pkg::IDX_TMR_ROUTE) begin
                route_reg <= pwdata[7:0];
            end
            if (regIdx == pio_pkg::IDX_NARROW_OUT) begin
                narrowOut_reg <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------------------------------------
    // Counter enable and sync control
    // ----------------------------------------------------------------------
    logic cntWr;
    pio_pkg::pio_cnt_ctrl_t cnt_next;

    assign cntWr = wrEn && regIdx == pio_pkg::IDX_CNT_CTRL;

    always_comb begin
        cnt_next = cntCtrl;
        if (cntWr) begin
            cnt_next.timer16bitEn = pwdata[pio_pkg::CNT_TIMER_16BIT_EN_BIT];
            cnt_next.timer8bitEn = pwdata[pio_pkg::CNT_TIMER_8BIT_EN_BIT];
            cnt_next.sync = pwdata[pio_pkg::CNT_SYNC_BIT];
        end else if (stopRecover) begin
            cnt_next.timer16bitEn = 1'b0;
            cnt_next.timer8bitEn = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cntCtrl <= '0;
            timer8bitStart <= 1'b0;
            timer16bitStart <= 1'b0;
        end else begin
            cntCtrl <= cnt_next;
            // Both starts come from one edge, so a synced double enable is aligned.
            timer8bitStart <= cnt_next.timer8bitEn & ~cntCtrl.timer8bitEn;
            timer16bitStart <= cnt_next.timer16bitEn & ~cntCtrl.timer16bitEn;
        end
    end

    // ----------------------------------------------------------------------
    // Wide-port drivers
    // ----------------------------------------------------------------------
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        pio_pin_drive u_drv (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .dirOut(portDir_reg[i]),
            .pushPull(portCfg_reg[pio_pkg::CFG_PUSH_PULL_BIT]),
            .dataOut(portOut_reg[i]),
            .pullOpt(pullSync),
            .padOut(widePortOut[i]),
            .padOe(widePortOe[i]),
            .padPullEn(widePortPullEn[i])
        );
    end

    // ----------------------------------------------------------------------
    // Wake-up, edge source, comparators and narrow outputs
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wakeAnd <= 1'b0;
            wakeOr <= 1'b0;
            edgeCaptureIn <= 1'b0;
            compPowerEn <= 1'b0;
            recoverySrc <= 3'h0;
        end else begin
            wakeAnd <= &wideSync;
            wakeOr <= |wideSync;
            edgeCaptureIn <= (edgeCaptureMode && portCfg_reg[pio_pkg::CFG_EDGE_SRC_BIT])
                ? wideSync[0] : narrowSync[0];
            compPowerEn <= portCfg_reg[pio_pkg::CFG_COMP_EN_BIT] & ~stopMode;
            // Narrow inputs reach recovery only in digital mode.
            recoverySrc <= portCfg_reg[pio_pkg::CFG_DIGITAL_BIT] ? narrowSync : 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            narrowPortOut <= 4'h0;
        end else begin
            narrowPortOut[0] <= route_reg[pio_pkg::ROUTE_TIMER_8BIT_BIT] ? timerOut.timer8bit
                : narrowOut_reg[0];
            narrowPortOut[1] <= portCfg_reg[pio_pkg::CFG_PIN5_SEL_BIT]
                ? (timerOut.timer16bit & route_reg[pio_pkg::ROUTE_TIMER_16BIT_BIT])
                : narrowOut_reg[1];
            narrowPortOut[2] <= (route_reg[pio_pkg::ROUTE_COMMON_HI:pio_pkg::ROUTE_COMMON_LO]
                != 2'h0) ? timerOut.combo : narrowOut_reg[2];
            narrowPortOut[3] <= narrowOut_reg[3];
        end
    end

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    logic afterReset_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            afterReset_reg <= 1'b1;
        end else begin
            afterReset_reg <= 1'b0;
        end
    end

    dir_follow_a: assert property (wrEn && regIdx == pio_pkg::IDX_PORT_DIR
        && pwdata[0] && portCfg_reg[pio_pkg::CFG_PUSH_PULL_BIT] |=> ##1 widePortOe[0])
        else $error("Direction write did not enable the line driver.");
    open_drain_a: assert property (!$past(portCfg_reg[pio_pkg::CFG_PUSH_PULL_BIT])
        |-> widePortOut == '0)
        else $error("Open-drain line drove a high level.");
    reset_input_a: assert property (afterReset_reg
        |-> portDir_reg == '0 && widePortOe == '0)
        else $error("A wide-port line is an output after reset.");
    pull_opt_a: assert property (widePortPullEn == {PORT_W{$past(pullSync)}})
        else $error("Pull-up enables do not follow the option.");
    wake_gate_a: assert property (wakeAnd == &$past(wideSync)
        && wakeOr == |$past(wideSync))
        else $error("Wake-up gates disagree with the port inputs.");
    edge_src_a: assert property (edgeCaptureMode
        && portCfg_reg[pio_pkg::CFG_EDGE_SRC_BIT] |=> edgeCaptureIn == $past(wideSync[0]))
        else $error("Edge detector is not fed from wide-port bit 0.");
    stop_comp_a: assert property (stopMode |=> !compPowerEn)
        else $error("Comparators stayed powered in stop mode.");
    pin5_sel_a: assert property (!portCfg_reg[pio_pkg::CFG_PIN5_SEL_BIT]
        |=> narrowPortOut[1] == $past(narrowOut_reg[1]))
        else $error("Pin 5 left normal output while deselected.");
    pin4_timer_a: assert property (route_reg[pio_pkg::ROUTE_TIMER_8BIT_BIT]
        |=> narrowPortOut[0] == $past(timerOut.timer8bit))
        else $error("Pin 4 does not show the 8-bit timer.");
    cnt_read_a: assert property (psel && penable && !pwrite && pready && !pslverr
        && regIdx == pio_pkg::IDX_CNT_CTRL |-> prdata[7:0] == {$past(cntCtrl), 5'h1f})
        else $error("Counter control readback is wrong.");
    enable_wr_a: assert property (cntWr
        |=> cntCtrl.timer8bitEn == $past(pwdata[6])
        && cntCtrl.timer16bitEn == $past(pwdata[7]))
        else $error("Counter enable write not applied.");
    sync_keep_a: assert property (stopRecover && !cntWr |=> $stable(cntCtrl.sync))
        else $error("Sync bit changed on stop-mode recovery.");
    sync_start_a: assert property (cntWr && pwdata[7:5] == 3'h7
        && !cntCtrl.timer8bitEn && !cntCtrl.timer16bitEn
        |=> timer8bitStart && timer16bitStart)
        else $error("Synced counters did not start together.");
    reset_cnt_a: assert property (afterReset_reg |-> cntCtrl == '0)
        else $error("Counter control not cleared by reset.");

    cover_sync_start_c: cover property (timer8bitStart && timer16bitStart && cntCtrl.sync);
    cover_wake_c: cover property (wakeAnd);
    cover_err_c: cover property (pslverr && pready);
    cover_od_c: cover property (widePortOe[0] && !widePortOut[0]);
endmodule
`default_nettype wire

// ---- testbench/pio_pin_model.sv ----
// Purpose: Pin-side model of the circuitry on the wide-port lines.
// Assumes: Pull-ups act only where the block enables them.
// Notes: A line nobody drives or pulls up toggles each cycle so a floating pin never looks stable.
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model (
    input wire logic clk_sys,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] pullEn,
    input wire logic [7:0] extVal,
    input wire logic [7:0] extEn,
    output logic [7:0] padIn
);
    // Starts low so a floating line toggles from a known level instead of staying unknown.
    logic [7:0] lastLvl = 8'h00;
    always @(posedge clk_sys) begin
        lastLvl <= padIn;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (padOe[i]) begin
                padIn[i] = padOut[i];
            end else if (extEn[i]) begin
                padIn[i] = extVal[i];
            end else if (pullEn[i]) begin
                padIn[i] = 1'b1;
            end else begin
                padIn[i] = ~lastLvl[i];
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/port_io_timer_output_ctrl_tb.sv ----
// Purpose: Self-checking bench for the port I/O and counter control block.
// Assumes: One-cycle APB answer; levels settle within a few clocks.
// Notes: Each scenario is a task that drives and judges on its own.
`timescale 1ns/1ps
`default_nettype none
module port_io_timer_output_ctrl_tb;
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, pullupOption;
    logic [7:0] paddr, widePortIn, widePortOut, widePortOe, widePortPullEn, extVal, extEn;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] narrowPortIn, recoverySrc;
    logic [3:0] narrowPortOut;
    logic edgeCaptureMode, stopMode, stopRecover, edgeCaptureIn, wakeAnd, wakeOr;
    logic compPowerEn, timer8bitStart, timer16bitStart, err;
    pio_pkg::pio_timer_out_t timerOut;
    pio_pkg::pio_cnt_ctrl_t cntCtrl;
    int mismatches = 0;
    int compares = 0;
    pio_top uut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .widePortIn(widePortIn),
        .widePortOut(widePortOut), .widePortOe(widePortOe), .widePortPullEn(widePortPullEn),
        .pullupOption(pullupOption), .narrowPortIn(narrowPortIn),
        .narrowPortOut(narrowPortOut), .timerOut(timerOut), .edgeCaptureMode(edgeCaptureMode),
        .stopMode(stopMode), .stopRecover(stopRecover), .edgeCaptureIn(edgeCaptureIn),
        .wakeAnd(wakeAnd), .wakeOr(wakeOr), .compPowerEn(compPowerEn),
        .recoverySrc(recoverySrc), .cntCtrl(cntCtrl), .timer8bitStart(timer8bitStart),
        .timer16bitStart(timer16bitStart));
    pio_pin_model pins (.clk_sys(clk_sys), .padOut(widePortOut), .padOe(widePortOe),
        .pullEn(widePortPullEn), .extVal(extVal), .extEn(extEn), .padIn(widePortIn));
    // ----------------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------------
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            print_verdict();
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge clk_sys);
    endtask
    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task automatic t_reset();
        chk("oe", 8'h00, widePortOe);
        chk("cnt", 3'b000, cntCtrl);
        apb(1'b0, 8'h0c, 32'h0);
        chk("cntrd", 32'h1f, rd);
        $display("test reset done");
    endtask
    task automatic t_wide();
        pullupOption <= 1'b1;
        settle();
        chk("pull", 8'hff, widePortPullEn);
        chk("and", 1'b1, wakeAnd);
        apb(1'b1, 8'h10, 32'h01);
        apb(1'b1, 8'h04, 32'h0f);
        settle();
        chk("oe", 8'h0f, widePortOe);
        chk("and", 1'b0, wakeAnd);
        chk("or", 1'b1, wakeOr);
        apb(1'b0, 8'h08, 32'h0);
        chk("pin", 32'hf0, rd);
        apb(1'b1, 8'h10, 32'h00);
        apb(1'b1, 8'h00, 32'h05);
        settle();
        chk("odoe", 8'h0a, widePortOe);
        chk("odout", 8'h00, widePortOut);
        apb(1'b1, 8'h04, 32'h00);
        pullupOption <= 1'b0;
        extEn <= 8'hff;
        extVal <= 8'h00;
        settle();
        chk("or", 1'b0, wakeOr);
        $display("test wide done");
    endtask
    task automatic t_counter();
        apb(1'b1, 8'h0c, 32'he0);
        @(posedge clk_sys);
        chk("starts", 2'b11, {timer8bitStart, timer16bitStart});
        apb(1'b0, 8'h0c, 32'h0);
        chk("cntrd", 32'hff, rd);
        @(posedge clk_sys);
        stopRecover <= 1'b1;
        @(posedge clk_sys);
        stopRecover <= 1'b0;
        apb(1'b0, 8'h0c, 32'h0);
        chk("sync", 32'h3f, rd);
        apb(1'b1, 8'h0c, 32'h00);
        apb(1'b0, 8'h0c, 32'h0);
        chk("stop", 32'h1f, rd);
        $display("test counter done");
    endtask
    task automatic t_narrow();
        apb(1'b1, 8'h18, 32'h0a);
        settle();
        chk("normal", 4'ha, narrowPortOut);
        apb(1'b1, 8'h18, 32'h00);
        apb(1'b1, 8'h14, 32'h13);
        apb(1'b1, 8'h10, 32'h02);
        timerOut <= 3'b111;
        settle();
        chk("route1", 3'b111, narrowPortOut[2:0]);
        timerOut <= 3'b110;
        settle();
        chk("route2", 3'b011, narrowPortOut[2:0]);
        timerOut <= 3'b000;
        settle();
        chk("route0", 3'b000, narrowPortOut[2:0]);
        $display("test narrow done");
    endtask
    task automatic t_misc();
        apb(1'b1, 8'h10, 32'h18);
        edgeCaptureMode <= 1'b1;
        extVal <= 8'h01;
        settle();
        chk("edge1", 1'b1, edgeCaptureIn);
        extVal <= 8'h00;
        settle();
        chk("edge0", 1'b0, edgeCaptureIn);
        chk("comp", 1'b1, compPowerEn);
        stopMode <= 1'b1;
        settle();
        chk("compstop", 1'b0, compPowerEn);
        apb(1'b1, 8'h10, 32'h04);
        narrowPortIn <= 3'b101;
        settle();
        chk("recov", 3'b101, recoverySrc);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped", 1'b1, err);
        apb(1'b0, 8'h0d, 32'h0);
        chk("misalign", 1'b1, err);
        $display("test misc done");
    endtask
    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, pullupOption, edgeCaptureMode, stopMode, stopRecover} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        narrowPortIn = 3'b000;
        timerOut = 3'b000;
        extVal = 8'h00;
        extEn = 8'h00;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_wide();
        t_counter();
        t_narrow();
        t_misc();
        print_verdict();
    end
endmodule
`default_nettype wire
